// File: ccd_pkg.sv
// Constants and types shared by the condition and opcode decode block.
// Assumes a single core clock domain with one asynchronous reset.
package ccd_pkg;

  // Special register addresses
  localparam logic [7:0] ADDR_MASK = 8'hfb;
  localparam logic [7:0] ADDR_FLAGS = 8'hfc;
  localparam logic [7:0] ADDR_GROUP_BASE = 8'hfd;

  // Flag bit positions inside the flags register
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;
  localparam logic [7:0] FLAGS_MASK = 8'hfc;
  localparam int MASK_EN_BIT = 7;

  // Values after reset
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] GROUP_BASE_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [15:0] PC_RST = 16'h0000;

  // Stack pointer steps
  localparam logic [15:0] SP_CALL_DEC = 16'h0002;
  localparam logic [15:0] SP_POP_FLAGS = 16'h0001;
  localparam logic [15:0] SP_POP_PC = 16'h0002;

  // Full opcodes
  localparam logic [7:0] OP_WDEC_RR = 8'h80;
  localparam logic [7:0] OP_WDEC_IR = 8'h81;
  localparam logic [7:0] OP_MASK_ALL = 8'h8f;
  localparam logic [7:0] OP_UNMASK = 8'h9f;
  localparam logic [7:0] OP_INT_RETURN = 8'hbf;
  localparam logic [7:0] OP_RET = 8'haf;
  localparam logic [7:0] OP_CALL_DA = 8'hd6;
  localparam logic [7:0] OP_CALL_IRR = 8'hd4;
  localparam logic [7:0] OP_CCF = 8'hef;
  localparam logic [7:0] OP_RCF = 8'hcf;
  localparam logic [7:0] OP_SCF = 8'hdf;
  localparam logic [7:0] OP_IDLE = 8'hff;

  // Nibble-coded opcode groups
  localparam logic [3:0] HI_ADD = 4'h0;
  localparam logic [3:0] HI_ADC = 4'h1;
  localparam logic [3:0] HI_AND = 4'h5;
  localparam logic [3:0] HI_COMPARE = 4'ha;
  localparam logic [3:0] LO_ARITH_MIN = 4'h2;
  localparam logic [3:0] LO_ARITH_MAX = 4'h7;
  localparam logic [3:0] LO_LOOP = 4'ha;
  localparam logic [3:0] LO_JP = 4'hd;
  localparam logic [3:0] LO_JR = 4'hb;

  // Instruction lengths in bytes
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;

  // Condition codes
  localparam logic [3:0] CC_NEVER = 4'h0;
  localparam logic [3:0] CC_SIGNED_BELOW = 4'h1;
  localparam logic [3:0] CC_SIGNED_AT_MOST = 4'h2;
  localparam logic [3:0] CC_UNSIGNED_AT_MOST = 4'h3;
  localparam logic [3:0] CC_RANGE_EXCEEDED = 4'h4;
  localparam logic [3:0] CC_SIGN_SET = 4'h5;
  localparam logic [3:0] CC_OPERANDS_MATCH = 4'h6;
  localparam logic [3:0] CC_CARRY = 4'h7;
  localparam logic [3:0] CC_ALWAYS = 4'h8;
  localparam logic [3:0] CC_SIGNED_AT_LEAST = 4'h9;
  localparam logic [3:0] CC_SIGNED_ABOVE = 4'ha;
  localparam logic [3:0] CC_UNSIGNED_ABOVE = 4'hb;
  localparam logic [3:0] CC_RANGE_OK = 4'hc;
  localparam logic [3:0] CC_SIGN_CLEAR = 4'hd;
  localparam logic [3:0] CC_OPERANDS_DIFFER = 4'he;
  localparam logic [3:0] CC_NO_CARRY = 4'hf;

  typedef enum logic [0:0] {ST_IDLE, ST_RETURN_PC} ccd_state_e;

  typedef struct packed {
    ccd_state_e st;
    logic [7:0] flags;
    logic [7:0] group_base;
    logic [7:0] mask;
    logic [15:0] sp;
    logic [15:0] pc;
    logic pc_load;
    logic [7:0] res;
    logic res_wr;
    logic [15:0] word;
    logic word_wr;
    logic stk_wr;
    logic [15:0] stk_data;
    logic [7:0] rd_data;
    logic [1:0] len;
  } ccd_regs_s;

endpackage

// File: ccd_cond_if.sv
// Carries a condition field and the flags to the evaluator and the verdict back.
// Assumes both ends sit in the core clock domain.
`timescale 1ns/1ns
interface ccd_cond_if;
  logic [3:0] code;
  logic [7:0] flags;
  logic cond_true;
  modport eval (input code, input flags, output cond_true);
  modport user (output code, output flags, input cond_true);
endinterface

// File: ccd_cond_eval.sv
// Pure combinational evaluation of a 4-bit condition field against the flags.
// Assumes flags laid out as in the shared package.
`timescale 1ns/1ns
module ccd_cond_eval
  import ccd_pkg::*;
(
  ccd_cond_if.eval cif // Condition in, verdict out
);
  logic c;
  logic z;
  logic s;
  logic v;
  logic sxv;
  assign c = cif.flags[FLAG_C];
  assign z = cif.flags[FLAG_Z];
  assign s = cif.flags[FLAG_S];
  assign v = cif.flags[FLAG_V];
  assign sxv = s ^ v;

  always_comb begin
    case (cif.code)
      CC_ALWAYS: cif.cond_true = 1'b1;
      CC_NEVER: cif.cond_true = 1'b0;
      CC_CARRY: cif.cond_true = c;
      CC_NO_CARRY: cif.cond_true = ~c;
      CC_OPERANDS_MATCH: cif.cond_true = z;
      CC_OPERANDS_DIFFER: cif.cond_true = ~z;
      CC_SIGN_CLEAR: cif.cond_true = ~s;
      CC_SIGN_SET: cif.cond_true = s;
      CC_RANGE_EXCEEDED: cif.cond_true = v;
      CC_RANGE_OK: cif.cond_true = ~v;
      CC_SIGNED_AT_LEAST: cif.cond_true = ~sxv;
      CC_SIGNED_BELOW: cif.cond_true = sxv;
      CC_SIGNED_ABOVE: cif.cond_true = ~(z | sxv);
      CC_SIGNED_AT_MOST: cif.cond_true = z | sxv;
      CC_UNSIGNED_ABOVE: cif.cond_true = ~c & ~z;
      CC_UNSIGNED_AT_MOST: cif.cond_true = c | z;
      default: cif.cond_true = 1'b0;
    endcase
  end
endmodule

// File: ccd_core.sv
// Opcode decode, flag update and control-register core for an 8-bit CPU.
// Assumes operands, targets and stack data are presented with the opcode, and the interrupt return PC one cycle later.
`timescale 1ns/1ns
module ccd_core
  import ccd_pkg::*;
(
  input wire logic clk_sys, // Core clock
  input wire logic arst_n, // Async reset, active low
  input wire logic op_valid, // Opcode byte present
  input wire logic [7:0] op_byte, // Opcode from program memory
  output logic op_ready, // Block can take an opcode
  input wire logic [7:0] dst_val, // Destination operand
  input wire logic [7:0] src_val, // Source operand
  input wire logic [15:0] word_val, // Register pair operand
  input wire logic [7:0] disp, // Relative displacement
  input wire logic [15:0] target_addr, // Jump or call target
  input wire logic [15:0] next_pc, // Address after this instruction
  input wire logic [15:0] stack_rd_data, // Data at stack_addr
  input wire logic reg_wr_en, // Register file write
  input wire logic [7:0] reg_wr_addr, // Register file write address
  input wire logic [7:0] reg_wr_data, // Register file write data
  input wire logic [7:0] reg_rd_addr, // Register file read address
  output logic [7:0] reg_rd_data, // Read data, one cycle later
  output logic [7:0] result_data, // Byte result for destination
  output logic result_wr, // Byte result strobe
  output logic [15:0] word_result, // Pair result
  output logic word_wr, // Pair result strobe
  output logic [15:0] pc_out, // Program counter
  output logic pc_load, // Program counter changed
  output logic [15:0] stack_addr, // Stack pointer
  output logic stack_wr, // Stack write strobe
  output logic [15:0] stack_wr_data, // Stack write data
  output logic [7:0] flags_out, // Flags register
  output logic [7:0] working_group_base, // Working group base
  output logic [7:0] interrupt_mask, // Interrupt mask register
  output logic [1:0] op_len // Length of last opcode
);
  ccd_regs_s r_reg;
  ccd_regs_s r_next;
  ccd_cond_if cif ();

  logic [3:0] hi;
  logic [3:0] lo;
  logic take;
  logic is_arith;
  logic is_add;
  logic is_adc;
  logic is_and;
  logic is_compare;
  logic is_wdec;
  logic is_call;
  logic is_loop;
  logic is_jp;
  logic is_jr;
  logic cin;
  logic [8:0] sum9;
  logic [4:0] half5;
  logic [8:0] diff9;
  logic [7:0] and8;
  logic [15:0] wdec;
  logic [7:0] ldec;
  logic [15:0] rel_pc;

  assign hi = op_byte[7:4];
  assign lo = op_byte[3:0];
  assign take = op_valid && (r_reg.st == ST_IDLE);
  assign is_arith = (lo >= LO_ARITH_MIN) && (lo <= LO_ARITH_MAX);
  assign is_add = is_arith && (hi == HI_ADD);
  assign is_adc = is_arith && (hi == HI_ADC);
  assign is_and = is_arith && (hi == HI_AND);
  assign is_compare = is_arith && (hi == HI_COMPARE);
  assign is_wdec = (op_byte == OP_WDEC_RR) || (op_byte == OP_WDEC_IR);
  assign is_call = (op_byte == OP_CALL_DA) || (op_byte == OP_CALL_IRR);
  assign is_loop = (lo == LO_LOOP) && !is_compare;
  assign is_jp = (lo == LO_JP);
  assign is_jr = (lo == LO_JR);

  assign cin = is_adc & r_reg.flags[FLAG_C];
  assign sum9 = {1'b0, dst_val} + {1'b0, src_val} + {8'h00, cin};
  assign half5 = {1'b0, dst_val[3:0]} + {1'b0, src_val[3:0]} + {4'h0, cin};
  assign diff9 = {1'b0, dst_val} - {1'b0, src_val};
  assign and8 = dst_val & src_val;
  assign wdec = word_val - 16'h0001;
  assign ldec = dst_val - 8'h01;
  assign rel_pc = next_pc + {{8{disp[7]}}, disp};

  // Upper nibble is the condition field for the conditional jumps
  assign cif.code = hi;
  assign cif.flags = r_reg.flags;

  ccd_cond_eval u_cond (
    .cif(cif)
  );

  always_comb begin
    r_next = r_reg;
    r_next.pc_load = 1'b0;
    r_next.res_wr = 1'b0;
    r_next.word_wr = 1'b0;
    r_next.stk_wr = 1'b0;
    case (reg_rd_addr)
      ADDR_FLAGS: r_next.rd_data = r_reg.flags & FLAGS_MASK;
      ADDR_GROUP_BASE: r_next.rd_data = r_reg.group_base;
      ADDR_MASK: r_next.rd_data = r_reg.mask;
      default: r_next.rd_data = 8'h00;
    endcase
    // Software writes first, so a same-cycle instruction effect wins
    if (reg_wr_en) begin
      case (reg_wr_addr)
        ADDR_FLAGS: r_next.flags = reg_wr_data & FLAGS_MASK;
        ADDR_GROUP_BASE: r_next.group_base = reg_wr_data;
        ADDR_MASK: r_next.mask = reg_wr_data;
        default: r_next.mask = r_next.mask;
      endcase
    end
    case (r_reg.st)
      ST_RETURN_PC: begin
        r_next.pc = stack_rd_data;
        r_next.sp = r_reg.sp + SP_POP_PC;
        r_next.pc_load = 1'b1;
        r_next.mask[MASK_EN_BIT] = 1'b1;
        r_next.st = ST_IDLE;
      end
      default: begin
        if (take) begin
          r_next.len = LEN_2;
          if (is_add || is_adc) begin
            r_next.res = sum9[7:0];
            r_next.res_wr = 1'b1;
            r_next.flags[FLAG_C] = sum9[8];
            r_next.flags[FLAG_Z] = (sum9[7:0] == 8'h00);
            r_next.flags[FLAG_S] = sum9[7];
            r_next.flags[FLAG_V] = (dst_val[7] == src_val[7]) && (sum9[7] != dst_val[7]);
            r_next.flags[FLAG_D] = 1'b0;
            r_next.flags[FLAG_H] = half5[4];
          end else if (is_and) begin
            r_next.res = and8;
            r_next.res_wr = 1'b1;
            r_next.flags[FLAG_Z] = (and8 == 8'h00);
            r_next.flags[FLAG_S] = and8[7];
            r_next.flags[FLAG_V] = 1'b0;
          end else if (is_compare) begin
            // Result is discarded; D and H are left alone
            r_next.flags[FLAG_C] = diff9[8];
            r_next.flags[FLAG_Z] = (diff9[7:0] == 8'h00);
            r_next.flags[FLAG_S] = diff9[7];
            r_next.flags[FLAG_V] = (dst_val[7] != src_val[7]) && (diff9[7] != dst_val[7]);
          end else if (is_wdec) begin
            r_next.word = wdec;
            r_next.word_wr = 1'b1;
            r_next.flags[FLAG_Z] = (wdec == 16'h0000);
            r_next.flags[FLAG_S] = wdec[15];
            r_next.flags[FLAG_V] = (word_val == 16'h8000);
          end else if (is_call) begin
            r_next.sp = r_reg.sp - SP_CALL_DEC;
            r_next.stk_wr = 1'b1;
            r_next.stk_data = next_pc;
            r_next.pc = target_addr;
            r_next.pc_load = 1'b1;
            r_next.len = (op_byte == OP_CALL_DA) ? LEN_3 : LEN_2;
          end else if (op_byte == OP_MASK_ALL) begin
            r_next.mask[MASK_EN_BIT] = 1'b0;
            r_next.len = LEN_1;
          end else if (op_byte == OP_UNMASK) begin
            r_next.mask[MASK_EN_BIT] = 1'b1;
            r_next.len = LEN_1;
          end else if (op_byte == OP_INT_RETURN) begin
            r_next.flags = stack_rd_data[7:0] & FLAGS_MASK;
            r_next.sp = r_reg.sp + SP_POP_FLAGS;
            r_next.st = ST_RETURN_PC;
            r_next.len = LEN_1;
          end else if (op_byte == OP_RET) begin
            r_next.pc = stack_rd_data;
            r_next.sp = r_reg.sp + SP_POP_PC;
            r_next.pc_load = 1'b1;
            r_next.len = LEN_1;
          end else if (op_byte == OP_CCF) begin
            r_next.flags[FLAG_C] = ~r_reg.flags[FLAG_C];
            r_next.len = LEN_1;
          end else if (op_byte == OP_RCF) begin
            r_next.flags[FLAG_C] = 1'b0;
            r_next.len = LEN_1;
          end else if (op_byte == OP_SCF) begin
            r_next.flags[FLAG_C] = 1'b1;
            r_next.len = LEN_1;
          end else if (op_byte == OP_IDLE) begin
            r_next.len = LEN_1;
          end else if (is_loop) begin
            r_next.res = ldec;
            r_next.res_wr = 1'b1;
            if (ldec != 8'h00) begin
              r_next.pc = rel_pc;
              r_next.pc_load = 1'b1;
            end
          end else if (is_jp) begin
            r_next.len = LEN_3;
            if (cif.cond_true) begin
              r_next.pc = target_addr;
              r_next.pc_load = 1'b1;
            end
          end else if (is_jr) begin
            if (cif.cond_true) begin
              r_next.pc = rel_pc;
              r_next.pc_load = 1'b1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '{st: ST_IDLE, flags: FLAGS_RST, group_base: GROUP_BASE_RST, mask: MASK_RST,
                 sp: SP_RST, pc: PC_RST, pc_load: 1'b0, res: 8'h00, res_wr: 1'b0,
                 word: 16'h0000, word_wr: 1'b0, stk_wr: 1'b0, stk_data: 16'h0000,
                 rd_data: 8'h00, len: LEN_1};
    end else begin
      r_reg <= r_next;
    end
  end

  assign op_ready = (r_reg.st == ST_IDLE);
  assign reg_rd_data = r_reg.rd_data;
  assign result_data = r_reg.res;
  assign result_wr = r_reg.res_wr;
  assign word_result = r_reg.word;
  assign word_wr = r_reg.word_wr;
  assign pc_out = r_reg.pc;
  assign pc_load = r_reg.pc_load;
  assign stack_addr = r_reg.sp;
  assign stack_wr = r_reg.stk_wr;
  assign stack_wr_data = r_reg.stk_data;
  assign flags_out = r_reg.flags;
  assign working_group_base = r_reg.group_base;
  assign interrupt_mask = r_reg.mask;
  assign op_len = r_reg.len;

  property p_cc_fixed;
    @(posedge clk_sys) disable iff (!arst_n)
    (cif.code == CC_ALWAYS |-> cif.cond_true) and (cif.code == CC_NEVER |-> !cif.cond_true);
  endproperty
  a_cc_fixed: assert property (p_cc_fixed) else $error("fixed condition code wrong");

  property p_jp_taken;
    @(posedge clk_sys) disable iff (!arst_n)
    take && is_jp && (hi == CC_CARRY) && r_reg.flags[FLAG_C]
      |=> pc_load && pc_out == $past(target_addr);
  endproperty
  a_jp_taken: assert property (p_jp_taken) else $error("carry jump not taken");

  property p_signed_below;
    @(posedge clk_sys) disable iff (!arst_n)
    take && is_jr && (hi == CC_SIGNED_BELOW) && !(r_reg.flags[FLAG_S] ^ r_reg.flags[FLAG_V])
      |=> !pc_load;
  endproperty
  a_signed_below: assert property (p_signed_below) else $error("signed below misjudged");

  property p_add;
    @(posedge clk_sys) disable iff (!arst_n)
    take && is_add |=> result_wr && !flags_out[FLAG_D] && flags_out[FLAG_C] == $past(sum9[8]);
  endproperty
  a_add: assert property (p_add) else $error("add result or flags wrong");

  property p_and;
    @(posedge clk_sys) disable iff (!arst_n)
    take && is_and && !reg_wr_en |=> !flags_out[FLAG_V] && $stable(flags_out[FLAG_C]);
  endproperty
  a_and: assert property (p_and) else $error("and flags wrong");

  property p_call;
    @(posedge clk_sys) disable iff (!arst_n)
    take && is_call |=> stack_wr && stack_addr == $past(stack_addr) - SP_CALL_DEC
      && stack_wr_data == $past(next_pc) ##1 (!stack_wr || $past(take && is_call));
  endproperty
  a_call: assert property (p_call) else $error("call stack push wrong");

  property p_compare;
    @(posedge clk_sys) disable iff (!arst_n)
    take && is_compare && !reg_wr_en |=> !result_wr && $stable(flags_out[FLAG_D])
      && $stable(flags_out[FLAG_H]);
  endproperty
  a_compare: assert property (p_compare) else $error("compare touched result or D/H");

  property p_wdec;
    @(posedge clk_sys) disable iff (!arst_n)
    take && is_wdec && !reg_wr_en |=> word_wr && $stable(flags_out[FLAG_C]);
  endproperty
  a_wdec: assert property (p_wdec) else $error("word decrement wrong");

  property p_mask_ops;
    @(posedge clk_sys) disable iff (!arst_n)
    take && (op_byte == OP_MASK_ALL) |=> !interrupt_mask[MASK_EN_BIT] && op_len == LEN_1;
  endproperty
  a_mask_ops: assert property (p_mask_ops) else $error("disable op did not clear mask");

  property p_loop;
    @(posedge clk_sys) disable iff (!arst_n)
    take && is_loop && (dst_val == 8'h01) |=> result_wr && result_data == 8'h00 && !pc_load;
  endproperty
  a_loop: assert property (p_loop) else $error("loop branched on zero");

  property p_int_return;
    @(posedge clk_sys) disable iff (!arst_n)
    take && (op_byte == OP_INT_RETURN) |=> !op_ready ##1 op_ready && pc_load
      && interrupt_mask[MASK_EN_BIT];
  endproperty
  a_int_return: assert property (p_int_return) else $error("interrupt return sequence wrong");
endmodule

// File: ccd_prog_mem.sv
// Program memory model: a fixed list of opcode bytes indexed by fetch_addr.
// Assumes the bench holds fetch_en and fetch_addr until the core takes the byte.
`timescale 1ns/1ns
module ccd_prog_mem (
  input wire logic clk_sys, // Core clock
  input wire logic fetch_en, // Fetch request
  input wire logic [4:0] fetch_addr, // Byte index
  output logic op_valid, // Byte present
  output logic [7:0] op_byte // Opcode byte
);
  localparam logic [127:0] PROG = 128'h021252a280810ad6d49f8fefcfdfffbf;
  logic [7:0] rom [32];
  logic [7:0] last_reg = 8'h00;
  initial begin
    for (int i = 0; i < 16; i++) begin
      rom[i] = {i[3:0], 4'hd};
      rom[16 + i] = PROG[127 - 8 * i -: 8];
    end
  end
  // Released bus shows the inverse of the last byte, not a stale copy
  assign op_valid = fetch_en;
  assign op_byte = fetch_en ? rom[fetch_addr] : ~last_reg;
  always @(posedge clk_sys) begin
    if (fetch_en) begin
      last_reg <= rom[fetch_addr];
    end
  end
endmodule

// File: tb_cond_code_and_opcode_decode.sv
// Self-checking bench for the decode core, fed by the program memory model.
// Assumes the core's package and the model are compiled first.
`timescale 1ns/1ns
module tb_cond_code_and_opcode_decode;
  import ccd_pkg::*;
  localparam logic [47:0] ARI [4] = '{48'h10087f018034, 48'h1180ff0000c4,
    48'h12fcf00f00cc, 48'h130c010200ac};
  localparam logic [23:0] ONE [6] = '{24'h195454, 24'h1a5454, 24'h1b8000,
    24'h1c8404, 24'h1d0484, 24'h1e5454};
  localparam logic [7:0] FPAT [7] = '{8'h00, 8'h80, 8'h40, 8'h20, 8'h10, 8'h30, 8'hc0};
  logic clk_sys, arst_n, fetch_en, op_valid, op_ready, reg_wr_en;
  logic result_wr, word_wr, pc_load, stack_wr;
  logic [4:0] fetch_addr;
  logic [7:0] op_byte, dst_val, src_val, disp, reg_wr_addr, reg_wr_data, reg_rd_addr;
  logic [7:0] reg_rd_data, result_data, flags_out, working_group_base, interrupt_mask;
  logic [15:0] word_val, target_addr, next_pc, stack_rd_data;
  logic [15:0] word_result, pc_out, stack_addr, stack_wr_data;
  logic [1:0] op_len;
  logic [47:0] r;
  logic exp_t;
  logic [15:0] exp_pc;
  int fails, num_checks, cycles;

  ccd_prog_mem pmem (.clk_sys, .fetch_en, .fetch_addr, .op_valid, .op_byte);
  ccd_core uut (.clk_sys, .arst_n, .op_valid, .op_byte, .op_ready, .dst_val, .src_val,
    .word_val, .disp, .target_addr, .next_pc, .stack_rd_data, .reg_wr_en, .reg_wr_addr,
    .reg_wr_data, .reg_rd_addr, .reg_rd_data, .result_data, .result_wr, .word_result,
    .word_wr, .pc_out, .pc_load, .stack_addr, .stack_wr, .stack_wr_data, .flags_out,
    .working_group_base, .interrupt_mask, .op_len);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_en = 1'b1;
    reg_wr_addr = a;
    reg_wr_data = d;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
    // Idle cycle so a following write never re-raises the strobe at once
    @(negedge clk_sys);
  endtask

  // Presets flags, then holds the fetch until the core takes it
  task automatic op(input logic [4:0] a, input logic [7:0] f);
    wr(ADDR_FLAGS, f);
    fetch_en = 1'b1;
    fetch_addr = a;
    while (op_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    fetch_en = 1'b0;
  endtask

  // Reference condition table; bit 3 inverts the base test
  function automatic logic cond(input logic [3:0] c, input logic [7:0] f);
    logic t;
    logic b;
    t = f[FLAG_S] ^ f[FLAG_V];
    case (c[2:0])
      3'h0: b = 1'b0;
      3'h1: b = t;
      3'h2: b = f[FLAG_Z] | t;
      3'h3: b = f[FLAG_C] | f[FLAG_Z];
      3'h4: b = f[FLAG_V];
      3'h5: b = f[FLAG_S];
      3'h6: b = f[FLAG_Z];
      default: b = f[FLAG_C];
    endcase
    return b ^ c[3];
  endfunction

  task automatic test_done();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole run needs well under 2000 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    {arst_n, fetch_en, fetch_addr, reg_wr_en, reg_wr_addr, reg_wr_data} = '0;
    {dst_val, src_val, disp, word_val, target_addr, next_pc, stack_rd_data} = '0;
    reg_rd_addr = ADDR_GROUP_BASE;
    repeat (20) @(negedge clk_sys);
    arst_n = 1'b1;
    check({op_ready, 6'h0, op_len}, {1'b1, 6'h0, LEN_1});
    check({working_group_base, interrupt_mask}, 16'h0000);
    check(flags_out, FLAGS_RST);
    wr(ADDR_GROUP_BASE, 8'h5a);
    check(working_group_base, 8'h5a);
    check(reg_rd_data, 8'h5a);
    wr(ADDR_MASK, 8'h6e);
    check(interrupt_mask, 8'h6e);
    wr(ADDR_MASK, 8'h00);
    wr(ADDR_FLAGS, 8'hff);
    wr(8'h10, 8'h33);
    check(flags_out, 8'hfc);
    check(working_group_base, 8'h5a);
    $display("registers done");
    exp_pc = PC_RST;
    for (int p = 0; p < 7; p++) begin
      for (int c = 0; c < 16; c++) begin
        target_addr = 16'(16'h4000 + p * 16 + c);
        exp_t = cond(4'(c), FPAT[p]);
        op(5'(c), FPAT[p]);
        if (exp_t) begin
          exp_pc = target_addr;
        end
        check(pc_load, exp_t);
        check(pc_out, exp_pc);
        check(flags_out, FPAT[p]);
      end
    end
    $display("conditions done");
    for (int i = 0; i < 4; i++) begin
      r = ARI[i];
      dst_val = r[31:24];
      src_val = r[23:16];
      op(r[44:40], r[39:32]);
      check(flags_out, r[7:0]);
      check(result_wr, i != 3);
      check(result_data, r[15:8]);
    end
    $display("arith done");
    word_val = 16'h8000;
    op(5'd20, 8'h80);
    check({word_wr, flags_out}, 16'h0190);
    check(word_result, 16'h7fff);
    word_val = 16'h0001;
    op(5'd21, 8'h00);
    check({word_wr, flags_out}, 16'h0140);
    check(word_result, 16'h0000);
    dst_val = 8'h01;
    op(5'd22, 8'h50);
    check({pc_load, result_wr, result_data}, 16'h0100);
    dst_val = 8'h05;
    disp = 8'hfe;
    next_pc = 16'h1000;
    op(5'd22, 8'h50);
    check({pc_load, result_wr, result_data}, 16'h0304);
    check({pc_out, flags_out}, 24'h0ffe50);
    $display("word and loop done");
    next_pc = 16'h2003;
    target_addr = 16'h3000;
    op(5'd23, 8'ha8);
    check({stack_addr, stack_wr_data}, 32'hfffe2003);
    check({stack_wr, pc_load, op_len, flags_out}, 16'h0fa8);
    check(pc_out, 16'h3000);
    next_pc = 16'h3002;
    target_addr = 16'h3100;
    op(5'd24, 8'h00);
    check({stack_addr, stack_wr_data}, 32'hfffc3002);
    check({stack_wr, pc_load, op_len}, 4'he);
    check(pc_out, 16'h3100);
    for (int i = 0; i < 6; i++) begin
      op(ONE[i][20:16], ONE[i][15:8]);
      check(op_len, LEN_1);
      check(flags_out, ONE[i][7:0]);
      check(interrupt_mask, {i == 0, 7'h0});
    end
    $display("call and single-byte done");
    stack_rd_data = 16'h00f7;
    op(5'd31, 8'h00);
    check({flags_out, 7'h0, op_ready}, 16'hf400);
    check(stack_addr, 16'hfffd);
    stack_rd_data = 16'h1234;
    @(negedge clk_sys);
    check({pc_out, pc_load, op_ready}, 18'h048d3);
    check({stack_addr, interrupt_mask}, 24'hffff80);
    $display("interrupt return done");
    test_done();
  end
endmodule
